// ==== rtl/volume_ramp_defs.svh ====
`ifndef VOLUME_RAMP_DEFS_SVH
`define VOLUME_RAMP_DEFS_SVH

// Register indices; the byte address is four times the index.
`define VR_IDX_MUTE_CTRL    8'h03
`define VR_IDX_LINK_SELECT  8'h3C
`define VR_IDX_RIGHT_GAIN   8'h3E
`define VR_IDX_NORMAL_RAMP  8'h3F
`define VR_IDX_EMERG_RAMP   8'h40
`define VR_IDX_STATUS       8'h70

// Reset values.
`define VR_RST_MUTE_CTRL    8'h00
`define VR_RST_LINK_SELECT  2'h0
`define VR_RST_RIGHT_GAIN   8'h30
`define VR_RST_NORMAL_RAMP  8'h33
`define VR_RST_EMERG_RAMP   8'h10

// Field positions.
`define VR_NDR_MSB 7
`define VR_NDR_LSB 6
`define VR_NDS_MSB 5
`define VR_NDS_LSB 4
`define VR_NUR_MSB 3
`define VR_NUR_LSB 2
`define VR_NUS_MSB 1
`define VR_NUS_LSB 0
`define VR_EDR_MSB 7
`define VR_EDR_LSB 6
`define VR_EDS_MSB 5
`define VR_EDS_LSB 4
`define VR_MUTE_BIT 0

// Gain codes and encodings.
`define VR_GAIN_MUTE    8'hFF
`define VR_RATE_INSTANT 2'h3
`define VR_LINK_FOLLOW  2'h1

// Timing: system clock and audio sample rate.
`define VR_CLOCK_HZ  100000000
`define VR_FS_HZ     96000
`define VR_FS_DIV    (`VR_CLOCK_HZ / `VR_FS_HZ)

`endif

// ==== rtl/volume_ramp_pkg.sv ====
package volume_ramp_pkg;

   // Ramp controller states, Gray coded along idle-down-muted-up.
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_DOWN  = 3'h1,
      ST_MUTED = 3'h3,
      ST_UP    = 3'h2,
      ST_EDOWN = 3'h6
   } ramp_state_t;

   // Rate and step pair of one ramp direction.
   typedef struct packed {
      logic [1:0] rate;
      logic [1:0] step;
   } ramp_cfg_t;

   // Captured address phase of a bus transfer.
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] index;
   } bus_addr_t;

endpackage : volume_ramp_pkg

// ==== rtl/ramp_tick_gen.sv ====
`timescale 1ns/10ps
`default_nettype none
module ramp_tick_gen #(
   parameter int FS_DIV = 1041
) (
   // Clock and reset.
   input  wire logic       clock,
   input  wire logic       rst_b,
   // Control.
   input  wire logic [1:0] rate,
   input  wire logic       restart,
   // Update strobe.
   output logic            updateTick
);

   localparam int CW = $clog2(FS_DIV);

   logic [CW-1:0] fsCnt_reg;
   logic [CW-1:0] fsCnt_next;
   logic [1:0]    phase_reg;
   logic [1:0]    phase_next;
   logic [1:0]    lastPhase;
   logic          fsTick;

   // Sample period divider and 1, 2 or 4 period update phase.
   always_comb begin
      fsTick = (fsCnt_reg == CW'(FS_DIV - 1));
      case (rate)
         2'h1:    lastPhase = 2'h1;
         2'h2:    lastPhase = 2'h3;
         default: lastPhase = 2'h0;
      endcase
      updateTick = fsTick && (phase_reg == lastPhase);
      fsCnt_next = fsTick ? '0 : fsCnt_reg + CW'(1);
      phase_next = phase_reg;
      if (fsTick) begin
         phase_next = (phase_reg == lastPhase) ? 2'h0 : phase_reg + 2'h1;
      end
      if (restart) begin
         fsCnt_next = '0;
         phase_next = 2'h0;
      end
   end

   // Registers of the divider.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         fsCnt_reg <= '0;
         phase_reg <= 2'h0;
      end else begin
         fsCnt_reg <= fsCnt_next;
         phase_reg <= phase_next;
      end
   end

endmodule : ramp_tick_gen
`default_nettype wire

// ==== rtl/digital_volume_ramp_control.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "volume_ramp_defs.svh"

// Function
// R1: Gain code 0x00 is +24 dB, each step -0.5 dB, 0x30 is 0 dB.
// R2: Code 0xFE is -103 dB, code 0xFF mutes the right channel.
// R3: Soft ramp-down updates every 1, 2, 4 sample periods; 11 mutes at once.
// R4: Soft ramp-down steps are 4, 2, 1 or 0.5 dB.
// R5: Ramp-up updates every 1, 2, 4 sample periods; 11 restores at once.
// R6: Ramp-up steps are 4, 2, 1 or 0.5 dB.
// R7: Soft mute from pin or register uses the normal ramp-down settings.
// R8: Soft unmute from pin or register uses the normal ramp-up settings.
// R9: Clock error or power loss ramps down at the emergency rate.
// R10: Emergency ramp-down steps are 4, 2, 1 or 0.5 dB.
// R11: Link select 01 makes the right channel use the left gain.
// R12: Ramps stop exactly at target or mute, clamping the last step.
module digital_volume_ramp_control
   import volume_ramp_pkg::*;
#(
   parameter int FS_DIV = `VR_FS_DIV
) (
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rst_b,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Mute sources and left channel setting.
   input  wire logic        soft_mute_pin_n,
   input  wire logic        clockError,
   input  wire logic        powerFail,
   input  wire logic [7:0]  leftGainCode,
   // Applied gain.
   output logic [7:0]       appliedGain,
   output logic             rampBusy,
   output logic             channelMuted
);

   ////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Step size in half-dB code units.
   function automatic logic [8:0] stepSize(input logic [1:0] sel);
      case (sel)
         2'h0:    stepSize = 9'h008;
         2'h1:    stepSize = 9'h004;
         2'h2:    stepSize = 9'h002;
         default: stepSize = 9'h001;
      endcase
   endfunction : stepSize

   // One step toward mute, clamped at the mute code.
   function automatic logic [7:0] stepDown(input logic [7:0] g,
                                           input logic [1:0] sel);
      logic [8:0] sum;
      sum = {1'b0, g} + stepSize(sel);
      stepDown = (sum > 9'h0FF) ? `VR_GAIN_MUTE : sum[7:0];
   endfunction : stepDown

   // One step toward the target, clamped at the target.
   function automatic logic [7:0] stepUp(input logic [7:0] g,
                                         input logic [1:0] sel,
                                         input logic [7:0] t);
      logic [8:0] dif;
      dif = {1'b0, g} - stepSize(sel);
      if (dif[8] || dif[7:0] <= t) begin
         stepUp = t;
      end else begin
         stepUp = dif[7:0];
      end
   endfunction : stepUp

   ////////////////////////////////////////////////////////////////////////
   // Register bus.

   bus_addr_t  addr_reg;
   bus_addr_t  addr_next;
   logic [7:0] muteCtrl_reg;
   logic [7:0] muteCtrl_next;
   logic [1:0] linkSel_reg;
   logic [1:0] linkSel_next;
   logic [7:0] rightGain_reg;
   logic [7:0] rightGain_next;
   logic [7:0] normRamp_reg;
   logic [7:0] normRamp_next;
   logic [7:0] emRamp_reg;
   logic [7:0] emRamp_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [7:0] gain_reg;
   logic [7:0] gain_next;
   ramp_state_t state_reg;
   ramp_state_t state_next;
   logic        accept;
   logic [7:0]  reqIndex;
   logic        inRange;

   // Slave never stalls and always answers OKAY.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_reg;

   // Address decode, register writes in the data phase, read mux.
   always_comb begin
      accept   = hsel && htrans[1] && hready;
      inRange  = (haddr[31:10] == 22'h0);
      reqIndex = haddr[9:2];
      addr_next.valid = accept && inRange;
      addr_next.write = hwrite;
      addr_next.index = reqIndex;
      muteCtrl_next  = muteCtrl_reg;
      linkSel_next   = linkSel_reg;
      rightGain_next = rightGain_reg;
      normRamp_next  = normRamp_reg;
      emRamp_next    = emRamp_reg;
      if (addr_reg.valid && addr_reg.write) begin
         case (addr_reg.index)
            `VR_IDX_MUTE_CTRL:   muteCtrl_next  = {7'h0, hwdata[0]};
            `VR_IDX_LINK_SELECT: linkSel_next   = hwdata[1:0];
            `VR_IDX_RIGHT_GAIN:  rightGain_next = hwdata[7:0];
            `VR_IDX_NORMAL_RAMP: normRamp_next  = hwdata[7:0];
            `VR_IDX_EMERG_RAMP:  emRamp_next    = {hwdata[7:4], 4'h0};
            default:             ;
         endcase
      end
      rdata_next = 32'h0000_0000;
      if (accept && inRange && !hwrite) begin
         case (reqIndex)
            `VR_IDX_MUTE_CTRL:   rdata_next = {24'h0, muteCtrl_next};
            `VR_IDX_LINK_SELECT: rdata_next = {30'h0, linkSel_next};
            `VR_IDX_RIGHT_GAIN:  rdata_next = {24'h0, rightGain_next};
            `VR_IDX_NORMAL_RAMP: rdata_next = {24'h0, normRamp_next};
            `VR_IDX_EMERG_RAMP:  rdata_next = {24'h0, emRamp_next};
            `VR_IDX_STATUS:      rdata_next = {20'h0, rampBusy,
                                               state_reg, gain_reg};
            default:             rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // Bus and configuration registers.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         addr_reg      <= '0;
         muteCtrl_reg  <= `VR_RST_MUTE_CTRL;
         linkSel_reg   <= `VR_RST_LINK_SELECT;
         rightGain_reg <= `VR_RST_RIGHT_GAIN;
         normRamp_reg  <= `VR_RST_NORMAL_RAMP;
         emRamp_reg    <= `VR_RST_EMERG_RAMP;
         rdata_reg     <= 32'h0000_0000;
      end else begin
         addr_reg      <= addr_next;
         muteCtrl_reg  <= muteCtrl_next;
         linkSel_reg   <= linkSel_next;
         rightGain_reg <= rightGain_next;
         normRamp_reg  <= normRamp_next;
         emRamp_reg    <= emRamp_next;
         rdata_reg     <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Ramp controller.

   ramp_cfg_t  downCfg;
   ramp_cfg_t  upCfg;
   ramp_cfg_t  emCfg;
   logic [1:0] tickRate;
   logic       updateTick;
   logic       muteReq;
   logic       emergReq;
   logic [7:0] target;

   // Field split and request sources.
   always_comb begin
      downCfg.rate = normRamp_reg[`VR_NDR_MSB:`VR_NDR_LSB];
      downCfg.step = normRamp_reg[`VR_NDS_MSB:`VR_NDS_LSB];
      upCfg.rate   = normRamp_reg[`VR_NUR_MSB:`VR_NUR_LSB];
      upCfg.step   = normRamp_reg[`VR_NUS_MSB:`VR_NUS_LSB];
      emCfg.rate   = emRamp_reg[`VR_EDR_MSB:`VR_EDR_LSB];
      emCfg.step   = emRamp_reg[`VR_EDS_MSB:`VR_EDS_LSB];
      muteReq  = !soft_mute_pin_n || muteCtrl_reg[`VR_MUTE_BIT]; // [R7] [R8]
      emergReq = clockError || powerFail; // [R9]
      target = (linkSel_reg == `VR_LINK_FOLLOW) ? leftGainCode
                                                : rightGain_reg; // [R11]
      case (state_reg)
         ST_DOWN:  tickRate = downCfg.rate;
         ST_UP:    tickRate = upCfg.rate;
         ST_EDOWN: tickRate = emCfg.rate;
         default:  tickRate = 2'h0;
      endcase
   end

   // Update strobe; restarts on every state change.
   ramp_tick_gen #(
      .FS_DIV     (FS_DIV)
   ) tickGen (
      .clock      (clock),
      .rst_b      (rst_b),
      .rate       (tickRate),
      .restart    (state_next != state_reg),
      .updateTick (updateTick)
   );

   // Next state and next applied gain code.
   always_comb begin
      state_next = state_reg;
      gain_next  = gain_reg;
      case (state_reg)
         ST_IDLE: begin
            gain_next = target; // [R1] [R11]
            if (emergReq) begin
               state_next = ST_EDOWN;
            end else if (muteReq) begin
               state_next = ST_DOWN; // [R7]
            end
         end
         ST_DOWN: begin
            if (emergReq) begin
               state_next = ST_EDOWN;
            end else if (!muteReq) begin
               state_next = ST_UP; // [R8]
            end else if (downCfg.rate == `VR_RATE_INSTANT) begin
               gain_next  = `VR_GAIN_MUTE; // [R3]
               state_next = ST_MUTED;
            end else if (updateTick) begin
               gain_next = stepDown(gain_reg, downCfg.step); // [R3] [R4]
               if (gain_next == `VR_GAIN_MUTE) begin
                  state_next = ST_MUTED; // [R12]
               end
            end
         end
         ST_EDOWN: begin
            if (emCfg.rate == `VR_RATE_INSTANT) begin
               gain_next  = `VR_GAIN_MUTE; // [R9]
               state_next = ST_MUTED;
            end else if (updateTick) begin
               gain_next = stepDown(gain_reg, emCfg.step); // [R9] [R10]
               if (gain_next == `VR_GAIN_MUTE) begin
                  state_next = ST_MUTED; // [R12]
               end
            end
         end
         ST_MUTED: begin
            gain_next = `VR_GAIN_MUTE; // [R2]
            if (!emergReq && !muteReq) begin
               state_next = ST_UP;
            end
         end
         ST_UP: begin
            if (emergReq) begin
               state_next = ST_EDOWN;
            end else if (muteReq) begin
               state_next = ST_DOWN;
            end else if (upCfg.rate == `VR_RATE_INSTANT
                         || gain_reg <= target) begin
               gain_next  = target; // [R5]
               state_next = ST_IDLE;
            end else if (updateTick) begin
               gain_next = stepUp(gain_reg, upCfg.step, target); // [R5] [R6]
               if (gain_next == target) begin
                  state_next = ST_IDLE; // [R12]
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Ramp state and applied gain registers.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
         gain_reg  <= `VR_RST_RIGHT_GAIN;
      end else begin
         state_reg <= state_next;
         gain_reg  <= gain_next;
      end
   end

   assign appliedGain  = gain_reg;
   assign rampBusy     = (state_reg != ST_IDLE) && (state_reg != ST_MUTED);
   assign channelMuted = (gain_reg == `VR_GAIN_MUTE);

   ////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   sequence downUpdate;
      state_reg == ST_DOWN && !emergReq && muteReq
         && downCfg.rate != `VR_RATE_INSTANT && updateTick;
   endsequence

   sequence upUpdate;
      state_reg == ST_UP && !emergReq && !muteReq
         && upCfg.rate != `VR_RATE_INSTANT && gain_reg > target && updateTick;
   endsequence

   sequence emUpdate;
      state_reg == ST_EDOWN && emCfg.rate != `VR_RATE_INSTANT && updateTick;
   endsequence

   idle_follows_a: assert property ( // [R1] [R11]
      state_reg == ST_IDLE ##1 state_reg == ST_IDLE
         |-> gain_reg == $past(target))
      else $error("idle gain does not follow the selected setting");

   muted_code_a: assert property ( // [R2]
      state_reg == ST_MUTED ##1 state_reg == ST_MUTED
         |-> gain_reg == `VR_GAIN_MUTE)
      else $error("muted state without the mute code");

   down_instant_a: assert property ( // [R3]
      state_reg == ST_DOWN && !emergReq && muteReq
         && downCfg.rate == `VR_RATE_INSTANT
         |=> gain_reg == `VR_GAIN_MUTE && state_reg == ST_MUTED)
      else $error("instant mute did not mute");

   down_hold_a: assert property ( // [R3]
      state_reg == ST_DOWN && !updateTick && !emergReq && muteReq
         && downCfg.rate != `VR_RATE_INSTANT |=> $stable(gain_reg))
      else $error("gain moved between ramp updates");

   down_step_a: assert property ( // [R4] [R12]
      downUpdate |=> gain_reg == stepDown($past(gain_reg),$past(downCfg.step)))
      else $error("ramp-down step wrong");

   up_instant_a: assert property ( // [R5]
      state_reg == ST_UP && !emergReq && !muteReq
         && upCfg.rate == `VR_RATE_INSTANT
         |=> gain_reg == $past(target) && state_reg == ST_IDLE)
      else $error("instant unmute did not restore");

   up_step_a: assert property ( // [R6] [R12]
      upUpdate |=> gain_reg
         == stepUp($past(gain_reg), $past(upCfg.step), $past(target)))
      else $error("ramp-up step wrong");

   soft_mute_a: assert property ( // [R7]
      state_reg == ST_IDLE && !emergReq && !soft_mute_pin_n
         |=> state_reg == ST_DOWN)
      else $error("soft mute pin did not start a ramp-down");

   unmute_a: assert property ( // [R8]
      state_reg == ST_MUTED && !emergReq && !muteReq
         |=> state_reg == ST_UP)
      else $error("unmute request did not start a ramp-up");

   emerg_start_a: assert property ( // [R9]
      state_reg == ST_IDLE && emergReq |=> state_reg == ST_EDOWN)
      else $error("emergency did not start a ramp-down");

   emerg_step_a: assert property ( // [R10] [R12]
      emUpdate |=> gain_reg == stepDown($past(gain_reg), $past(emCfg.step)))
      else $error("emergency step wrong");

endmodule : digital_volume_ramp_control
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "volume_ramp_defs.svh"
module tb_top
   import volume_ramp_pkg::*;
;
   localparam int FS_DIV = 4;
   localparam int LIMIT  = 50000;

   // Clock, reset and bus.
   logic        clock;
   logic        rst_b;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   wire logic   hready;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   // Mute sources and outputs.
   logic        soft_mute_pin_n;
   logic        clockError;
   logic        powerFail;
   logic [7:0]  leftGainCode;
   logic [7:0]  appliedGain;
   logic        rampBusy;
   logic        channelMuted;
   // Bench state and model.
   int          failCount;
   int          numChecks;
   int          cycles;
   int          seed = 32'h9ae6_3ad6;
   int          mGain;
   int          tgt;
   int          ur;
   int          us;
   logic [31:0] rd;

   // The single slave drives the bus ready.
   assign hready = hreadyout;

   digital_volume_ramp_control #(
      .FS_DIV(FS_DIV)
   ) i_digital_volume_ramp_control (
      .clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .soft_mute_pin_n(soft_mute_pin_n),
      .clockError(clockError), .powerFail(powerFail),
      .leftGainCode(leftGainCode), .appliedGain(appliedGain),
      .rampBusy(rampBusy), .channelMuted(channelMuted));

   ////////////////////////////////////////////////////////////////////////////
   // Clock generator.
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Cycle counter that cuts a hang short.
   always @(posedge clock) begin
      cycles++;
      if (cycles > LIMIT) begin
         failCount++;
         endSim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then stops.
   task automatic endSim();
      $display("checks %0d mismatches %0d", numChecks, failCount);
      if (failCount == 0 && numChecks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : endSim

   // Compares a seen value with the expected one.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         failCount++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One bus transfer: address phase, then data phase until hready.
   task automatic bus(input bit wr, input logic [7:0] idx,
                      input logic [31:0] data);
      hsel   <= 1'b1;
      haddr  <= {22'h0, idx, 2'b00};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clock); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wr ? data : 32'h0;
      do @(posedge clock); while (hready !== 1'b1);
      rd = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask : bus

   // Waits until the ramp controller leaves its busy states.
   task automatic wait_idle();
      int n;
      n = 0;
      while (rampBusy !== 1'b0 && n < 60) begin
         @(posedge clock);
         n++;
      end
      check({31'h0, rampBusy}, 32'h0);
   endtask : wait_idle

   // Follows a ramp to its end, checking each update against the model.
   task automatic ramp_watch(input int rate, input int step, input int endv);
      int cnt;
      int nxt;
      int n;
      int st;
      n  = 0;
      st = 8 >> step;
      while (mGain != endv) begin
         cnt = 0;
         do begin
            @(posedge clock);
            cnt++;
         end while (appliedGain === mGain[7:0] && cnt < 42);
         if (rate == 3) nxt = endv;
         else if (endv > mGain) nxt = (mGain + st > endv) ? endv : mGain + st;
         else nxt = (mGain - st < endv) ? endv : mGain - st;
         check({24'h0, appliedGain}, nxt);
         if (n > 0) check(cnt, (1 << rate) * FS_DIV);
         mGain = nxt;
         n++;
      end
   endtask : ramp_watch

   // Sets a fresh target gain while idle; the output follows at once.
   task automatic new_target();
      tgt = 32'h0000_00b0 + ($random(seed) & 32'h0000_003f);
      bus(1'b1, `VR_IDX_RIGHT_GAIN, tgt);
      repeat (2) @(posedge clock);
      check({24'h0, appliedGain}, tgt);
      mGain = tgt;
   endtask : new_target

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      int dr;
      int ds;
      int er;
      int es;
      int nr;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      soft_mute_pin_n = 1'b1;
      clockError = 1'b0;
      powerFail = 1'b0;
      leftGainCode = 8'h00;
      rst_b = 1'b0;
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      // Reset values, read-back and an unmapped place.
      check({24'h0, appliedGain}, 32'h0000_0030);
      bus(1'b0, `VR_IDX_RIGHT_GAIN, 0);
      check(rd, 32'h0000_0030);
      bus(1'b0, `VR_IDX_STATUS, 0);
      check(rd, 32'h0000_0030);
      bus(1'b0, `VR_IDX_MUTE_CTRL, 0);
      check(rd, 32'h0);
      bus(1'b0, `VR_IDX_LINK_SELECT, 0);
      check(rd, 32'h0);
      bus(1'b0, `VR_IDX_NORMAL_RAMP, 0);
      check(rd, 32'h0000_0033);
      bus(1'b0, `VR_IDX_EMERG_RAMP, 0);
      check(rd, 32'h0000_0010);
      bus(1'b1, `VR_IDX_EMERG_RAMP, 32'h0000_00ff);
      bus(1'b0, `VR_IDX_EMERG_RAMP, 0);
      check(rd, 32'h0000_00f0);
      bus(1'b0, 8'h7f, 0);
      check(rd, 32'h0);
      bus(1'b1, `VR_IDX_RIGHT_GAIN, 32'h0000_00fe);
      repeat (2) @(posedge clock);
      check({24'h0, appliedGain}, 32'h0000_00fe);
      check({31'h0, channelMuted}, 32'h0);
      // Every normal down rate and step, from the pin or the register.
      for (int i = 0; i < 16; i++) begin
         dr = i >> 2;
         ds = i & 3;
         ur = $random(seed) & 3;
         us = $random(seed) & 3;
         new_target();
         nr = (dr << 6) | (ds << 4) | (ur << 2) | us;
         bus(1'b1, `VR_IDX_NORMAL_RAMP, nr);
         bus(1'b0, `VR_IDX_NORMAL_RAMP, 0);
         check(rd, nr);
         if (i % 2 == 0) soft_mute_pin_n <= 1'b0;
         else bus(1'b1, `VR_IDX_MUTE_CTRL, 32'h1);
         ramp_watch(dr, ds, 255);
         wait_idle();
         check({31'h0, channelMuted}, 32'h1);
         if (i % 2 == 0) soft_mute_pin_n <= 1'b1;
         else bus(1'b1, `VR_IDX_MUTE_CTRL, 32'h0);
         ramp_watch(ur, us, tgt);
         wait_idle();
         check({31'h0, channelMuted}, 32'h0);
      end
      // Emergency ramps from either source, then unmute at the normal rate.
      for (int j = 0; j < 4; j++) begin
         er = j;
         es = $random(seed) & 3;
         new_target();
         bus(1'b1, `VR_IDX_EMERG_RAMP, (er << 6) | (es << 4));
         if (j % 2 == 1) clockError <= 1'b1;
         else powerFail <= 1'b1;
         ramp_watch(er, es, 255);
         clockError <= 1'b0;
         powerFail  <= 1'b0;
         ramp_watch(ur, us, tgt);
         wait_idle();
      end
      // Right channel following the left setting, then independent again.
      leftGainCode <= 8'($random(seed));
      bus(1'b1, `VR_IDX_LINK_SELECT, 32'h1);
      repeat (3) @(posedge clock);
      check({24'h0, appliedGain}, {24'h0, leftGainCode});
      bus(1'b1, `VR_IDX_LINK_SELECT, 32'h0);
      repeat (3) @(posedge clock);
      check({24'h0, appliedGain}, tgt);
      endSim();
   end
endmodule : tb_top
`default_nettype wire
